// >>> core/pmc_pkg.sv
// Purpose: constants for the lower control fields of the PCI miscellaneous configuration register
// Assumes: register is reached by PCI configuration cycles at its own dword offset
// Notes: bits 31 to 11 of the register are owned elsewhere and read as zero here
//
// Contract
// (R01) Vendor-ID bit 26 reads 1 while the PME-ignores-master-gate field is set, else 0.
// (R02) PME follows unmasked interrupts gated by the master gate, or ignores the gate when set.
// (R03) Long master reads use MRL for 00, MR for 01, MRM for 10 and MRM for 11.
// (R04) Master reads of one or two data phases always use plain memory read.
// (R05) PM version reports 010b when the select bit is 0 and 011b when 1; the bit resets to 1.
// (R06) Bits 6 to 5 always read zero and ignore writes.
// (R07) Access to a stopped link register target-aborts when no-abort is 0, else returns FFh.
// (R08) The no-target-abort bit resets to 1 and software should keep it at 1.
// (R09) The serial-bus enable bit is stored, resets to 0 and has no effect.
// (R10) Link-clock gate disable at 0 lets hardware auto-gate the link clock; 1 stops it.
// (R11) PCI-clock gate disable at 0 lets hardware auto-gate the PCI clock; 1 stops it.
// (R12) The keep-PCI-clock bit is stored, resets to 0 and has no effect.
// (R13) Writable fields return to reset on fundamental reset, global reset or power-on reset.
// (R14) Configuration reads return the last written value of every writable field, code 11 too.
package pmc_pkg;
  localparam logic [7:0] REG_OFFSET = 8'hf0;
  localparam int BIT_KEEP_PCLK = 0;
  localparam int BIT_PCI_GATE_DIS = 1;
  localparam int BIT_LINK_GATE_DIS = 2;
  localparam int BIT_SERIAL_BUS = 3;
  localparam int BIT_NO_TGT_ABORT = 4;
  localparam int BIT_PM_VERSION = 7;
  localparam int BIT_RD_CMD_LO = 8;
  localparam int BIT_PME_IGNORE = 10;
  localparam logic [10:0] REG_RESET = 11'h290;
  localparam logic [10:0] REG_WMASK = 11'h79f;
  localparam logic [1:0] RDSEL_MRL = 2'h0;
  localparam logic [1:0] RDSEL_MR = 2'h1;
  localparam logic [1:0] RDSEL_MRM = 2'h2;
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;
  localparam logic [3:0] CMD_MEM_READ_MULT = 4'hc;
  localparam logic [2:0] PM_VER_1P1 = 3'h2;
  localparam logic [2:0] PM_VER_1P2 = 3'h3;
  localparam logic [7:0] STOPPED_LINK_DATA = 8'hff;
  localparam int SYNC_STAGES = 3;
endpackage

// >>> core/pmc_pin_sync.sv
// Purpose: bring an asynchronous pin into the clk domain
// Assumes: pin may change at any time
// Notes: output moves only when the second and third stages agree
`timescale 1ns/100ps
module pmc_pin_sync #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pinIn,
  output logic levelOut
);
  logic [pmc_pkg::SYNC_STAGES-1:0] stage_q;
  logic [pmc_pkg::SYNC_STAGES-1:0] stage_d;
  logic level_q;
  logic level_d;

  always_comb begin
    stage_d = {stage_q[pmc_pkg::SYNC_STAGES-2:0], pinIn};
    level_d = (stage_q[1] == stage_q[2]) ? stage_q[2] : level_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_q <= {pmc_pkg::SYNC_STAGES{IDLE_LEVEL}};
      level_q <= IDLE_LEVEL;
    end else begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end

  assign levelOut = level_q;
endmodule

// >>> core/pmc_misc_config.sv
// Purpose: lower eleven control bits of the PCI misc configuration register and their effects
// Assumes: config and link requests come from logic on clk; reset pins are asynchronous
// Notes: every answer appears one clock after its request
`timescale 1ns/100ps
module pmc_misc_config #(
  parameter int IRQ_BITS = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pcieFundResetN,
  input wire logic globalResetInputN,
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWrData,
  output logic [31:0] cfgRdData,
  output logic cfgRdValid,
  input wire logic [IRQ_BITS-1:0] irqEvents,
  input wire logic [IRQ_BITS-1:0] irqMask,
  input wire logic masterInterruptGate,
  output logic pmeRequest,
  output logic vendorIdBit26,
  input wire logic masterReadReq,
  input wire logic masterReadLong,
  output logic [3:0] masterReadCmd,
  output logic masterReadCmdValid,
  output logic [2:0] pmVersion,
  input wire logic linkAccess,
  input wire logic linkClockStopped,
  output logic linkTargetAbort,
  output logic linkStoppedRespValid,
  output logic [7:0] linkStoppedRespData,
  output logic linkClockGateEnable,
  output logic pciClockGateEnable
);
  ////////////////////////////////////////////////////////////////////////////////
  // reset pins
  logic fundResetLevel;
  logic globalResetLevel;
  logic fieldReset;

  pmc_pin_sync #(.IDLE_LEVEL(1'b1)) uFundSync (
    .clk(clk),
    .rst(rst),
    .pinIn(pcieFundResetN),
    .levelOut(fundResetLevel)
  );

  pmc_pin_sync #(.IDLE_LEVEL(1'b1)) uGlobalSync (
    .clk(clk),
    .rst(rst),
    .pinIn(globalResetInputN),
    .levelOut(globalResetLevel)
  );

  // filtered pin resets clear the fields like power-on, but only on a clock edge,
  // so a glitch shorter than one clock never disturbs the stored fields
  assign fieldReset = !fundResetLevel || !globalResetLevel;

  ////////////////////////////////////////////////////////////////////////////////
  // register fields
  logic [10:0] ctrl_q;
  logic [10:0] ctrl_d;
  logic [10:0] wrBits;
  logic [10:0] wrEnable;
  logic cfgHit;

  assign cfgHit = (cfgAddr == pmc_pkg::REG_OFFSET);
  assign wrBits = cfgWrData[10:0];
  // byte 0 carries bits 7:0 and byte 1 bits 10:8; bytes 2 and 3 have nothing to store here
  assign wrEnable = {{3{cfgByteEn[1]}}, {8{cfgByteEn[0]}}} & pmc_pkg::REG_WMASK; // R06

  always_comb begin
    ctrl_d = ctrl_q;
    if (fieldReset) begin
      ctrl_d = pmc_pkg::REG_RESET; // R13 R08 R05
    end else if (cfgWrite && cfgHit) begin
      ctrl_d = (ctrl_q & ~wrEnable) | (wrBits & wrEnable); // R09 R12 R14
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= pmc_pkg::REG_RESET; // R13
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // config read answer
  logic [31:0] rdData_q;
  logic [31:0] rdData_d;
  logic rdValid_q;
  logic rdValid_d;

  always_comb begin
    rdValid_d = cfgRead && cfgHit;
    rdData_d = rdData_q;
    if (cfgRead && cfgHit) begin
      rdData_d = {21'h000000, ctrl_q & pmc_pkg::REG_WMASK}; // R06 R14
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_q <= 32'h00000000;
      rdValid_q <= 1'b0;
    end else begin
      rdData_q <= rdData_d;
      rdValid_q <= rdValid_d;
    end
  end

  assign cfgRdData = rdData_q;
  assign cfgRdValid = rdValid_q;

  ////////////////////////////////////////////////////////////////////////////////
  // field effects
  logic pmeIgnore;
  logic [1:0] rdSel;
  logic pme_q;
  logic pme_d;
  logic bit26_q;
  logic bit26_d;
  logic [3:0] cmd_q;
  logic [3:0] cmd_d;
  logic cmdValid_q;
  logic cmdValid_d;
  logic [2:0] ver_q;
  logic [2:0] ver_d;
  logic linkGate_q;
  logic linkGate_d;
  logic pciGate_q;
  logic pciGate_d;

  assign pmeIgnore = ctrl_q[pmc_pkg::BIT_PME_IGNORE];
  assign rdSel = ctrl_q[pmc_pkg::BIT_RD_CMD_LO +: 2];

  always_comb begin
    bit26_d = pmeIgnore; // R01
    pme_d = (|(irqEvents & irqMask)) && (masterInterruptGate || pmeIgnore); // R02
    cmdValid_d = masterReadReq;
    cmd_d = cmd_q;
    if (masterReadReq) begin
      if (!masterReadLong) begin
        cmd_d = pmc_pkg::CMD_MEM_READ; // R04
      end else if (rdSel == pmc_pkg::RDSEL_MRL) begin
        cmd_d = pmc_pkg::CMD_MEM_READ_LINE; // R03
      end else if (rdSel == pmc_pkg::RDSEL_MR) begin
        cmd_d = pmc_pkg::CMD_MEM_READ; // R03
      end else begin
        // code 11 behaves like the reset code but stays stored for read-back
        cmd_d = pmc_pkg::CMD_MEM_READ_MULT; // R03
      end
    end
    ver_d = ctrl_q[pmc_pkg::BIT_PM_VERSION] ? pmc_pkg::PM_VER_1P2 : pmc_pkg::PM_VER_1P1; // R05
    linkGate_d = !ctrl_q[pmc_pkg::BIT_LINK_GATE_DIS]; // R10
    pciGate_d = !ctrl_q[pmc_pkg::BIT_PCI_GATE_DIS]; // R11
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit26_q <= 1'b0;
      pme_q <= 1'b0;
      cmd_q <= pmc_pkg::CMD_MEM_READ;
      cmdValid_q <= 1'b0;
      ver_q <= pmc_pkg::PM_VER_1P2;
      linkGate_q <= 1'b1;
      pciGate_q <= 1'b1;
    end else begin
      bit26_q <= bit26_d;
      pme_q <= pme_d;
      cmd_q <= cmd_d;
      cmdValid_q <= cmdValid_d;
      ver_q <= ver_d;
      linkGate_q <= linkGate_d;
      pciGate_q <= pciGate_d;
    end
  end

  assign vendorIdBit26 = bit26_q;
  assign pmeRequest = pme_q;
  assign masterReadCmd = cmd_q;
  assign masterReadCmdValid = cmdValid_q;
  assign pmVersion = ver_q;
  assign linkClockGateEnable = linkGate_q;
  assign pciClockGateEnable = pciGate_q;

  ////////////////////////////////////////////////////////////////////////////////
  // accesses to link registers whose clock is stopped
  logic abort_q;
  logic abort_d;
  logic resp_q;
  logic resp_d;
  logic [7:0] respData_q;
  logic [7:0] respData_d;
  logic stoppedHit;

  assign stoppedHit = linkAccess && linkClockStopped;

  always_comb begin
    abort_d = stoppedHit && !ctrl_q[pmc_pkg::BIT_NO_TGT_ABORT]; // R07
    resp_d = stoppedHit && ctrl_q[pmc_pkg::BIT_NO_TGT_ABORT]; // R07 R08
    respData_d = resp_d ? pmc_pkg::STOPPED_LINK_DATA : 8'h00; // R07
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      abort_q <= 1'b0;
      resp_q <= 1'b0;
      respData_q <= 8'h00;
    end else begin
      abort_q <= abort_d;
      resp_q <= resp_d;
      respData_q <= respData_d;
    end
  end

  assign linkTargetAbort = abort_q;
  assign linkStoppedRespValid = resp_q;
  assign linkStoppedRespData = respData_q;
endmodule

// >>> test/pmc_host_model.sv
// Purpose: PCI host issuing config cycles
// Assumes: strobes sampled on rising clk
// Notes: released address and data lines show inverted values; byte enables hold
`timescale 1ns/100ps
module pmc_host_model (
  input wire logic clk,
  input wire logic [31:0] cfgRdData,
  input wire logic cfgRdValid,
  output logic cfgWrite,
  output logic cfgRead,
  output logic [7:0] cfgAddr,
  output logic [3:0] cfgByteEn,
  output logic [31:0] cfgWrData
);
  initial begin
    cfgWrite = 0;
    cfgRead = 0;
    cfgAddr = 0;
    cfgByteEn = 0;
    cfgWrData = 0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wrbe(a, d, 4'h3);
  endtask
  task automatic wrbe(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    cfgWrite <= 1'b1;
    cfgAddr <= a;
    cfgByteEn <= be;
    cfgWrData <= d;
    @(posedge clk);
    cfgWrite <= 1'b0;
    cfgAddr <= ~a;
    cfgWrData <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
    @(posedge clk);
    cfgRead <= 1'b1;
    cfgAddr <= a;
    @(posedge clk);
    cfgRead <= 1'b0;
    cfgAddr <= ~a;
    #1;
    v = cfgRdValid;
    d = cfgRdData;
  endtask
endmodule

// >>> test/pmc_misc_config_asserts.sv
// Purpose: port checks
// Assumes: one clock
// Notes: bound to pmc_misc_config
`timescale 1ns/100ps
module pmc_misc_config_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [31:0] cfgRdData,
  input wire logic cfgRdValid,
  input wire logic masterReadReq,
  input wire logic masterReadLong,
  input wire logic [3:0] masterReadCmd,
  input wire logic masterReadCmdValid,
  input wire logic linkAccess,
  input wire logic linkClockStopped,
  input wire logic linkTargetAbort,
  input wire logic linkStoppedRespValid,
  input wire logic [7:0] linkStoppedRespData
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence stopAcc; linkAccess && linkClockStopped; endsequence
  sequence oneAns; ##1 (linkTargetAbort ^ linkStoppedRespValid); endsequence
  AST_RD_ACK: assert property (cfgRead && cfgAddr == 8'hf0 |=> cfgRdValid)
    else $error("read not answered");
  AST_RD_HIT: assert property (cfgRdValid |-> $past(cfgRead && cfgAddr == 8'hf0))
    else $error("stray read answer");
  AST_RSVD: assert property (cfgRdValid |-> cfgRdData[31:11] == 0 && cfgRdData[6:5] == 0)
    else $error("reserved bits set");
  AST_SHORT: assert property (masterReadReq && !masterReadLong |=> masterReadCmd == 4'h6)
    else $error("short read cmd");
  AST_MR_ACK: assert property (masterReadReq |=> masterReadCmdValid)
    else $error("no cmd valid");
  AST_STOP: assert property (stopAcc |-> oneAns)
    else $error("stopped access answer");
  AST_NOSTOP: assert property (!(linkAccess && linkClockStopped) |=> !linkTargetAbort && !linkStoppedRespValid)
    else $error("answer without stop");
  AST_FF: assert property (linkStoppedRespValid |-> linkStoppedRespData == 8'hff)
    else $error("resp data");
endmodule
bind pmc_misc_config pmc_misc_config_asserts u_chk (.*);

// >>> test/tb_top.sv
// Purpose: bench for pmc_misc_config
// Assumes: host model drives config port
// Notes: reset pins are filtered
`timescale 1ns/100ps
module tb_top;
  logic clk = 0, rst = 1, pcieFundResetN = 1, globalResetInputN = 1;
  logic cfgWrite, cfgRead, cfgRdValid, pmeRequest, vendorIdBit26, masterReadCmdValid;
  logic linkTargetAbort, linkStoppedRespValid, linkClockGateEnable, pciClockGateEnable;
  logic masterInterruptGate = 0, masterReadReq = 0, masterReadLong = 0;
  logic linkAccess = 0, linkClockStopped = 0, v;
  logic [7:0] cfgAddr, linkStoppedRespData;
  logic [3:0] cfgByteEn, masterReadCmd;
  logic [2:0] pmVersion;
  logic [31:0] cfgWrData, cfgRdData, irqEvents = 0, irqMask = 0, rdv;
  logic [3:0] expCmd [4] = '{4'he, 4'h6, 4'hc, 4'hc};
  int error_cnt = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  pmc_misc_config u_pmc_misc_config (.*);
  pmc_host_model u_pmc_host_model (.*);
  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic ev);
    u_pmc_host_model.rd(a, rdv, v);
    chk("valid", v, ev);
    if (ev) chk("rdata", rdv, e);
  endtask
  task automatic fields(input logic [31:0] w, e, input logic [5:0] lv);
    u_pmc_host_model.wr(8'hf0, w);
    rdchk(8'hf0, e, 1'b1);
    chk("levels", {pmVersion, vendorIdBit26, linkClockGateEnable, pciClockGateEnable}, lv);
  endtask
  task automatic lanes;
    u_pmc_host_model.wr(8'hf0, 32'h0);
    u_pmc_host_model.wrbe(8'hf0, 32'hffffffff, 4'h2);
    rdchk(8'hf0, 32'h700, 1'b1);
    u_pmc_host_model.wrbe(8'hf0, 32'hffffffff, 4'hc);
    rdchk(8'hf0, 32'h700, 1'b1);
  endtask
  task automatic mrq(input logic l, input logic [3:0] e);
    @(posedge clk);
    masterReadReq <= 1'b1;
    masterReadLong <= l;
    @(posedge clk);
    masterReadReq <= 1'b0;
    masterReadLong <= ~l;
    #1;
    chk("mrcmd", {masterReadCmdValid, masterReadCmd}, {1'b1, e});
  endtask
  task automatic lnk(input logic s, ab, rv);
    @(posedge clk);
    linkAccess <= 1'b1;
    linkClockStopped <= s;
    @(posedge clk);
    linkAccess <= 1'b0;
    linkClockStopped <= 1'b0;
    #1;
    chk("link", {linkTargetAbort, linkStoppedRespValid, linkStoppedRespData},
      {ab, rv, rv ? 8'hff : 8'h00});
  endtask
  task automatic pme(input logic [31:0] f, input logic g, m, e);
    @(posedge clk);
    irqEvents <= 32'h4;
    irqMask <= {29'h0, m, 2'h0};
    masterInterruptGate <= g;
    u_pmc_host_model.wr(8'hf0, f);
    repeat (2) @(posedge clk);
    #1;
    chk("pme", pmeRequest, e);
  endtask
  task automatic pinrst(input logic p);
    u_pmc_host_model.wr(8'hf0, 32'h0);
    @(posedge clk);
    pcieFundResetN <= p;
    globalResetInputN <= ~p;
    repeat (6) @(posedge clk);
    pcieFundResetN <= 1'b1;
    globalResetInputN <= 1'b1;
    repeat (6) @(posedge clk);
    rdchk(8'hf0, 32'h290, 1'b1);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk(8'hf0, 32'h290, 1'b1);
    chk("rstlv", {pmVersion, vendorIdBit26, linkClockGateEnable, pciClockGateEnable}, 6'h1b);
    fields(32'hffffffff, 32'h79f, 6'h1c);
    fields(32'h0, 32'h0, 6'h13);
    rdchk(8'hf4, 32'h0, 1'b0);
    lanes();
    for (int c = 0; c < 4; c++) begin
      u_pmc_host_model.wr(8'hf0, c << 8);
      mrq(1'b1, expCmd[c]);
      mrq(1'b0, 4'h6);
    end
    lnk(1'b1, 1'b1, 1'b0);
    lnk(1'b0, 1'b0, 1'b0);
    u_pmc_host_model.wr(8'hf0, 32'h10);
    lnk(1'b1, 1'b0, 1'b1);
    pme(32'h0, 1'b0, 1'b1, 1'b0);
    pme(32'h400, 1'b0, 1'b1, 1'b1);
    pme(32'h0, 1'b1, 1'b1, 1'b1);
    pme(32'h400, 1'b1, 1'b0, 1'b0);
    pinrst(1'b0);
    pinrst(1'b1);
    give_verdict();
  end
endmodule
